/* File: rhp_host_port.sv */
// router host port: time code pins, push and pop fifos, axi4-lite registers
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module rhp_host_port #(
    parameter int DEPTH  = rhp_pkg::FIFO_DEPTH,
    parameter int MARGIN = rhp_pkg::FLAG_MARGIN
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    // time code pins
    input  wire logic                       tick_in,
    input  wire logic [rhp_pkg::TIME_W-1:0] time_code_in,
    output logic      [rhp_pkg::TIME_W-1:0] time_code_out,
    output logic                            time_code_oe_n,
    output logic                            tick_out,
    // host fifo pins
    input  wire logic                       port_select_n,
    input  wire logic                       push_n,
    input  wire logic [rhp_pkg::WORD_W-1:0] tx_data,
    input  wire logic                       pop_n,
    input  wire logic                       output_enable_n,
    output logic      [rhp_pkg::WORD_W-1:0] rx_data,
    output logic                            rx_data_oe_n,
    output logic                            send_queue_full,
    output logic                            send_queue_nearly_full,
    output logic                            receive_queue_empty,
    output logic                            receive_queue_nearly_empty,
    // link side
    input  wire logic                       link_run,
    input  wire logic                       tx_char_done,
    output logic                            tx_time_send,
    output logic      [rhp_pkg::TIME_W-1:0] tx_time_value,
    input  wire logic                       rx_time_valid,
    input  wire logic [rhp_pkg::TIME_W-1:0] rx_time_value,
    output logic                            link_tx_valid,
    input  wire logic                       link_tx_ready,
    output logic      [rhp_pkg::WORD_W-1:0] link_tx_data,
    input  wire logic                       link_rx_valid,
    output logic                            link_rx_ready,
    input  wire logic [rhp_pkg::WORD_W-1:0] link_rx_data,
    // axi4-lite slave
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [rhp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [rhp_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic      [1:0]                 s_axi_bresp,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [rhp_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic      [rhp_pkg::DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    output logic                            irq
);
    logic                         ctrl_time_drive;
    logic [rhp_pkg::IRQ_W-1:0]    irq_status;
    logic [rhp_pkg::IRQ_W-1:0]    irq_mask;
    logic [rhp_pkg::ADDR_W-1:0]   wr_addr;
    logic [rhp_pkg::DATA_W-1:0]   wr_data;
    logic                         wr_lane0;
    logic                         tx_full;
    logic                         tx_empty;
    logic                         rx_full;
    logic                         rx_empty;
    logic                         time_pending;
    logic [rhp_pkg::TIME_W-1:0]   time_count;
    logic                         time_arrived;

    ////////////////////////////////////////////////////////////////////////////
    // host strobes, active low, qualified by port select
    wire host_push = ~push_n & ~port_select_n;
    wire host_pop  = ~pop_n & ~port_select_n;

    // send queue: host fills, link drains
    rhp_fifo #(
        .WIDTH  (rhp_pkg::WORD_W),
        .DEPTH  (DEPTH),
        .MARGIN (MARGIN)
    ) u_send_queue (
        .clock        (clock),
        .rst_n        (rst_n),
        .wr_en        (host_push),
        .wr_data      (tx_data),
        .rd_en        (link_tx_ready),
        .rd_data      (link_tx_data),
        .full         (tx_full),
        .not_full     (),
        .nearly_full  (send_queue_nearly_full),
        .empty        (tx_empty),
        .not_empty    (link_tx_valid),
        .nearly_empty ()
    );

    // receive queue: link fills, host drains
    rhp_fifo #(
        .WIDTH  (rhp_pkg::WORD_W),
        .DEPTH  (DEPTH),
        .MARGIN (MARGIN)
    ) u_receive_queue (
        .clock        (clock),
        .rst_n        (rst_n),
        .wr_en        (link_rx_valid),
        .wr_data      (link_rx_data),
        .rd_en        (host_pop),
        .rd_data      (rx_data),
        .full         (rx_full),
        .not_full     (link_rx_ready),
        .nearly_full  (),
        .empty        (rx_empty),
        .not_empty    (),
        .nearly_empty (receive_queue_nearly_empty)
    );

    assign send_queue_full     = tx_full;
    assign receive_queue_empty = rx_empty;

    // time code request and arrival
    rhp_time u_time (
        .clock         (clock),
        .rst_n         (rst_n),
        .tick_in       (tick_in),
        .time_value_in (time_code_in),
        .link_run      (link_run),
        .tx_char_done  (tx_char_done),
        .rx_time_valid (rx_time_valid),
        .rx_time_value (rx_time_value),
        .tx_time_send  (tx_time_send),
        .tx_time_value (tx_time_value),
        .tick_out      (time_arrived),
        .time_count    (time_count),
        .pending       (time_pending)
    );

    assign tick_out      = time_arrived;
    assign time_code_out = time_count;

    ////////////////////////////////////////////////////////////////////////////
    // pin enables; software says when the shared time bus is driven, so no bus fight
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_oe_n   <= 1'b1;
            time_code_oe_n <= 1'b1;
        end else begin
            rx_data_oe_n   <= output_enable_n | port_select_n;
            time_code_oe_n <= ~ctrl_time_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events, set beats clear in the same cycle
    wire [rhp_pkg::IRQ_W-1:0] events;
    assign events[rhp_pkg::IRQ_TIME_ARRIVED_BIT] = time_arrived;
    assign events[rhp_pkg::IRQ_TIME_SENT_BIT]    = tx_time_send;
    assign events[rhp_pkg::IRQ_PUSH_REFUSED_BIT] = host_push & tx_full;
    assign events[rhp_pkg::IRQ_POP_REFUSED_BIT]  = host_pop & rx_empty;

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken independently, answered together
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire b_done  = s_axi_bvalid & s_axi_bready;
    wire wr_ctrl = wr_go & wr_lane0 & (wr_addr == rhp_pkg::CTRL_OFFSET);
    wire wr_mask = wr_go & wr_lane0 & (wr_addr == rhp_pkg::IRQ_MASK_OFFSET);
    wire wr_clr  = wr_go & wr_lane0 & (wr_addr == rhp_pkg::IRQ_STATUS_OFFSET);
    wire wr_hit  = (wr_addr == rhp_pkg::CTRL_OFFSET)
                 | (wr_addr == rhp_pkg::STATUS_OFFSET)
                 | (wr_addr == rhp_pkg::IRQ_STATUS_OFFSET)
                 | (wr_addr == rhp_pkg::IRQ_MASK_OFFSET)
                 | (wr_addr == rhp_pkg::TIME_OFFSET);
    wire [rhp_pkg::IRQ_W-1:0] clear_bits = wr_clr ? wr_data[rhp_pkg::IRQ_W-1:0] : '0;
    wire [rhp_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~clear_bits) | events;

    // capture of address and data words
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr  <= '0;
            wr_data  <= '0;
            wr_lane0 <= 1'b0;
        end else begin
            wr_addr  <= aw_take ? s_axi_awaddr : wr_addr;
            wr_data  <= w_take ? s_axi_wdata : wr_data;
            wr_lane0 <= w_take ? s_axi_wstrb[0] : wr_lane0;
        end
    end

    // write handshake; readies reopen once the response is taken
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= rhp_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= b_done | (s_axi_awready & ~aw_take);
            s_axi_wready  <= b_done | (s_axi_wready & ~w_take);
            s_axi_bvalid  <= wr_go | (s_axi_bvalid & ~s_axi_bready);
            s_axi_bresp   <= wr_go ? (wr_hit ? rhp_pkg::RESP_OKAY : rhp_pkg::RESP_SLVERR)
                                   : s_axi_bresp;
        end
    end

    // software registers and the interrupt line
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_time_drive <= rhp_pkg::CTRL_TIME_DRIVE_RESET;
            irq_mask        <= rhp_pkg::IRQ_MASK_RESET;
            irq_status      <= '0;
            irq             <= 1'b0;
        end else begin
            ctrl_time_drive <= wr_ctrl ? wr_data[rhp_pkg::CTRL_TIME_DRIVE_BIT]
                                       : ctrl_time_drive;
            irq_mask        <= wr_mask ? wr_data[rhp_pkg::IRQ_W-1:0] : irq_mask;
            irq_status      <= next_irq_status;
            irq             <= |(next_irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read decode; status shows live queue and link state
    wire [rhp_pkg::DATA_W-1:0] status_word;
    assign status_word = {26'h0, time_pending, link_run, receive_queue_nearly_empty,
                          rx_empty, send_queue_nearly_full, tx_full};
    wire ar_take  = s_axi_arvalid & s_axi_arready;
    wire r_done   = s_axi_rvalid & s_axi_rready;
    wire rd_ctrl  = s_axi_araddr == rhp_pkg::CTRL_OFFSET;
    wire rd_stat  = s_axi_araddr == rhp_pkg::STATUS_OFFSET;
    wire rd_isr   = s_axi_araddr == rhp_pkg::IRQ_STATUS_OFFSET;
    wire rd_imr   = s_axi_araddr == rhp_pkg::IRQ_MASK_OFFSET;
    wire rd_time  = s_axi_araddr == rhp_pkg::TIME_OFFSET;
    wire rd_hit   = rd_ctrl | rd_stat | rd_isr | rd_imr | rd_time;
    wire [rhp_pkg::DATA_W-1:0] rd_word =
          rd_ctrl ? {31'h0, ctrl_time_drive}
        : rd_stat ? status_word
        : rd_isr  ? {28'h0, irq_status}
        : rd_imr  ? {28'h0, irq_mask}
        : rd_time ? {24'h0, time_count}
        : 32'h0;

    // read handshake, data one cycle after the address
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= rhp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= r_done | (s_axi_arready & ~ar_take);
            s_axi_rvalid  <= ar_take | (s_axi_rvalid & ~s_axi_rready);
            s_axi_rdata   <= ar_take ? rd_word : s_axi_rdata;
            s_axi_rresp   <= ar_take ? (rd_hit ? rhp_pkg::RESP_OKAY : rhp_pkg::RESP_SLVERR)
                                     : s_axi_rresp;
        end
    end
endmodule

/* File: rhp_pkg.sv */
// shared constants for the host port
package rhp_pkg;
    // data path widths and fifo shape
    localparam int WORD_W      = 9;
    localparam int TIME_W      = 8;
    localparam int FIFO_DEPTH  = 128;
    localparam int FLAG_MARGIN = 8;
    // register bus
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET       = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET     = 12'h004;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 12'h008;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET   = 12'h00C;
    localparam logic [ADDR_W-1:0] TIME_OFFSET       = 12'h010;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // control register fields
    localparam int CTRL_TIME_DRIVE_BIT = 0;
    localparam logic CTRL_TIME_DRIVE_RESET = 1'h0;
    // status register fields
    localparam int STAT_TX_FULL_BIT         = 0;
    localparam int STAT_TX_NEARLY_FULL_BIT  = 1;
    localparam int STAT_RX_EMPTY_BIT        = 2;
    localparam int STAT_RX_NEARLY_EMPTY_BIT = 3;
    localparam int STAT_LINK_RUN_BIT        = 4;
    localparam int STAT_TIME_PENDING_BIT    = 5;
    // interrupt status and mask fields
    localparam int IRQ_W                 = 4;
    localparam int IRQ_TIME_ARRIVED_BIT  = 0;
    localparam int IRQ_TIME_SENT_BIT     = 1;
    localparam int IRQ_PUSH_REFUSED_BIT  = 2;
    localparam int IRQ_POP_REFUSED_BIT   = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [TIME_W-1:0] TIME_RESET     = 8'h00;
endpackage

/* File: rhp_fifo.sv */
// synchronous fifo with registered head word and level flags
`timescale 1ns/1ps
module rhp_fifo #(
    parameter int WIDTH  = rhp_pkg::WORD_W,
    parameter int DEPTH  = rhp_pkg::FIFO_DEPTH,
    parameter int MARGIN = rhp_pkg::FLAG_MARGIN
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  full,
    output logic                  not_full,
    output logic                  nearly_full,
    output logic                  empty,
    output logic                  not_empty,
    output logic                  nearly_empty
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_NF   = CNT_W'(DEPTH - MARGIN);
    localparam logic [CNT_W-1:0] CNT_NE   = CNT_W'(MARGIN);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;

    ////////////////////////////////////////////////////////////////////////////
    // refused moves change nothing
    wire              wr_go      = wr_en & ~full;
    wire              rd_go      = rd_en & ~empty;
    wire [PTR_W-1:0]  next_wr    = wr_ptr + PTR_W'(1);
    wire [PTR_W-1:0]  next_rd    = rd_go ? rd_ptr + PTR_W'(1) : rd_ptr;
    wire [CNT_W-1:0]  next_count = count + CNT_W'(wr_go) - CNT_W'(rd_go);
    // a word written into the slot the head moves to must bypass the array
    wire              bypass     = wr_go && (wr_ptr == next_rd);

    ////////////////////////////////////////////////////////////////////////////
    // storage array, no reset so it maps onto ram
    always_ff @(posedge clock) begin
        if (wr_go) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    // head word register, new word shows after the popping edge
    always_ff @(posedge clock) begin
        rd_data <= bypass ? wr_data : mem[next_rd];
    end

    // pointers and occupancy
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= wr_go ? next_wr : wr_ptr;
            rd_ptr <= next_rd;
            count  <= next_count;
        end
    end

    // flags follow the move that crosses their threshold
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            full         <= 1'b0;
            not_full     <= 1'b1;
            nearly_full  <= 1'b0;
            empty        <= 1'b1;
            not_empty    <= 1'b0;
            nearly_empty <= 1'b1;
        end else begin
            full         <= next_count == CNT_FULL;
            not_full     <= next_count != CNT_FULL;
            nearly_full  <= next_count >= CNT_NF;
            empty        <= next_count == '0;
            not_empty    <= next_count != '0;
            nearly_empty <= next_count <= CNT_NE;
        end
    end
endmodule

/* File: rhp_time.sv */
// time code request, send and arrival logic
`timescale 1ns/1ps
module rhp_time (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      tick_in,
    input  wire logic [rhp_pkg::TIME_W-1:0] time_value_in,
    input  wire logic                      link_run,
    input  wire logic                      tx_char_done,
    input  wire logic                      rx_time_valid,
    input  wire logic [rhp_pkg::TIME_W-1:0] rx_time_value,
    output logic                           tx_time_send,
    output logic      [rhp_pkg::TIME_W-1:0] tx_time_value,
    output logic                           tick_out,
    output logic      [rhp_pkg::TIME_W-1:0] time_count,
    output logic                           pending
);
    // request captured only while the link runs
    wire take_req  = tick_in & link_run & ~pending;
    // sent at the end of the character in flight, not at a packet end
    wire send_now  = pending & link_run & tx_char_done;
    // only the successor of the counter is a valid code
    wire rx_good   = link_run & rx_time_valid
                   & (rx_time_value == time_count + rhp_pkg::TIME_W'(1));

    ////////////////////////////////////////////////////////////////////////////
    // pending request and its value; a dropped link cancels it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pending       <= 1'b0;
            tx_time_value <= rhp_pkg::TIME_RESET;
        end else begin
            pending       <= link_run & (take_req | (pending & ~send_now));
            tx_time_value <= take_req ? time_value_in : tx_time_value;
        end
    end

    // one cycle send strobe towards the link transmitter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_time_send <= 1'b0;
        end else begin
            tx_time_send <= send_now;
        end
    end

    // arrival strobe and counter update
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_out   <= 1'b0;
            time_count <= rhp_pkg::TIME_RESET;
        end else begin
            tick_out   <= rx_good;
            time_count <= rx_good ? rx_time_value : time_count;
        end
    end
endmodule

/* File: rhp_chk.sv */
// assertion checker for the host port pins
`timescale 1ns/1ps
module rhp_chk (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       tick_out,
    input wire logic       tx_time_send,
    input wire logic       output_enable_n,
    input wire logic       port_select_n,
    input wire logic       rx_data_oe_n,
    input wire logic       receive_queue_empty,
    input wire logic       receive_queue_nearly_empty,
    input wire logic       send_queue_full,
    input wire logic       send_queue_nearly_full,
    input wire logic       link_run,
    input wire logic       rx_time_valid,
    input wire logic [7:0] rx_time_value,
    input wire logic [7:0] time_code_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // one past the counter, 8-bit wrap
    wire good_code = link_run && rx_time_valid && rx_time_value == 8'(time_code_out + 8'h01);
    ////////////////////////////////////////////////////////////////////////////
    AST_TICK_PULSE: assert property (tick_out |=> !tick_out)
        else $error("tick_out too long");
    AST_SEND_PULSE: assert property (tx_time_send |=> !tx_time_send)
        else $error("tx_time_send too long");
    AST_OE_FOLLOWS: assert property (rx_data_oe_n == $past(output_enable_n|port_select_n))
        else $error("rx_data_oe_n wrong");
    AST_EMPTY_NEAR: assert property (receive_queue_empty |-> receive_queue_nearly_empty)
        else $error("empty without nearly empty");
    AST_FULL_NEAR: assert property (send_queue_full |-> send_queue_nearly_full)
        else $error("full without nearly full");
    AST_TIME_HOLD: assert property ($changed(time_code_out) |-> tick_out)
        else $error("time_code_out moved alone");
    AST_GOOD_CODE: assert property (good_code |=> tick_out && time_code_out == $past(rx_time_value))
        else $error("good code missed");
    AST_BAD_CODE: assert property (!good_code |=> !tick_out)
        else $error("stray tick_out");
    // main scenarios reached
    cover property (tick_out);
    cover property (tx_time_send);
    cover property (send_queue_full);
endmodule
bind rhp_host_port rhp_chk u_chk (.*);

/* File: rhp_link_model.sv */
// link side partner model
`timescale 1ns/1ps
module rhp_link_model (
    input  wire logic       clock,
    output logic            link_tx_ready = 1'b0,
    output logic            link_rx_valid = 1'b0,
    input  wire logic       link_rx_ready,
    output logic      [8:0] link_rx_data  = 9'h000,
    output logic            tx_char_done  = 1'b0,
    output logic            rx_time_valid = 1'b0,
    output logic      [7:0] rx_time_value = 8'h00
);
    logic       stall = 1'b0;
    logic [1:0] phase = 2'h0;
    // a character ends every fourth cycle; ready every other cycle
    always @(posedge clock) begin
        phase <= phase + 2'h1;
        tx_char_done <= (phase == 2'h3);
        link_tx_ready <= !stall && phase[0];
    end
    // words 100h+i; inverted once released
    task automatic feed(input int n);
        for (int i = 0; i < n; i++) begin
            link_rx_valid <= 1'b1;
            link_rx_data <= 9'h100 + 9'(i);
            @(posedge clock);
            while (!link_rx_ready) @(posedge clock);
        end
        link_rx_valid <= 1'b0;
        link_rx_data <= ~link_rx_data;
    endtask
    // one-cycle received time code
    task automatic send_code(input logic [7:0] v);
        @(posedge clock);
        rx_time_valid <= 1'b1;
        rx_time_value <= v;
        @(posedge clock);
        rx_time_valid <= 1'b0;
        rx_time_value <= ~v;
    endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the host port
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0, rst_n = 1'b0, tick_in = 1'b0, link_run = 1'b1, port_select_n = 1'b1;
    logic push_n = 1'b1, pop_n = 1'b1, output_enable_n = 1'b1;
    logic [7:0] time_code_in = 8'h00;
    logic [8:0] tx_data = 9'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] time_code_out, tx_time_value, rx_time_value;
    logic [8:0] rx_data, link_tx_data, link_rx_data;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic time_code_oe_n, tick_out, rx_data_oe_n, send_queue_full, send_queue_nearly_full;
    logic receive_queue_empty, receive_queue_nearly_empty, tx_char_done, tx_time_send;
    logic rx_time_valid, link_tx_valid, link_tx_ready, link_rx_valid, link_rx_ready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [31:0] exp_w[$], exp_t[$];
    int bad_count = 0, checks_done = 0;
    localparam logic [1:0] OK = rhp_pkg::RESP_OKAY;
    rhp_host_port #(.DEPTH(16)) dut (.*);
    rhp_link_model mdl (.*);
    always #2.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (e !== s) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    // write: aw and w together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", 32'(r), 32'(s_axi_bresp));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check("rresp", 32'(r), 32'(s_axi_rresp));
        check("rdata", d, s_axi_rdata);
    endtask
    task automatic finish_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watcher: results meet the oldest note
    always @(posedge clock) begin
        if (link_tx_valid && link_tx_ready)
            check("link_tx_data", exp_w.size() ? exp_w.pop_front() : 32'hX, 32'(link_tx_data));
        if (tick_out)
            check("time_code_out", exp_t.size() ? exp_t.pop_front() : 32'hX, 32'(time_code_out));
        if (tx_time_send)
            check("tx_time_value", exp_t.size() ? exp_t.pop_front() : 32'hX, 32'(tx_time_value));
    end
    // hang guard
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
    initial begin
        logic [8:0] w;
        void'($urandom(44));
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(rhp_pkg::STATUS_OFFSET, 32'h1C, OK);
        wr(rhp_pkg::CTRL_OFFSET, 32'h1, OK);
        @(negedge clock);
        check("time_code_oe_n", 32'h0, 32'(time_code_oe_n));
        rd(12'h100, 32'h0, rhp_pkg::RESP_SLVERR);
        wr(12'h100, 32'h1, rhp_pkg::RESP_SLVERR);
        // fill the stalled send queue one past full
        mdl.stall <= 1'b1;
        for (int i = 1; i <= 17; i++) begin
            w = 9'($urandom);
            if (i <= 16) exp_w.push_back(32'(w));
            @(posedge clock);
            {push_n, port_select_n} <= 2'h0;
            tx_data <= w;
            @(posedge clock);
            {push_n, port_select_n} <= 2'h3;
            tx_data <= ~w;
            #1;
            check("nearly_full", 32'(i >= 8), 32'(send_queue_nearly_full));
            check("full", 32'(i >= 16), 32'(send_queue_full));
        end
        rd(rhp_pkg::IRQ_STATUS_OFFSET, 32'h4, OK);
        check("irq", 32'h0, 32'(irq));
        wr(rhp_pkg::IRQ_MASK_OFFSET, 32'h4, OK);
        @(negedge clock);
        check("irq", 32'h1, 32'(irq));
        wr(rhp_pkg::IRQ_STATUS_OFFSET, 32'h4, OK);
        @(negedge clock);
        check("irq", 32'h0, 32'(irq));
        mdl.stall <= 1'b0;
        while (exp_w.size() > 0) @(posedge clock);
        // ten words in, popped in order, one pop too many
        mdl.feed(10);
        {port_select_n, output_enable_n} <= 2'h0;
        @(posedge clock);
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            check("rx_data", 32'(9'h100 + 9'(i)), 32'(rx_data));
            check("nearly_empty", 32'(i >= 2), 32'(receive_queue_nearly_empty));
            check("rx_data_oe_n", 32'h0, 32'(rx_data_oe_n));
            pop_n <= 1'b0;
            @(posedge clock);
            pop_n <= 1'b1;
        end
        @(negedge clock);
        check("empty", 32'h1, 32'(receive_queue_empty));
        @(posedge clock);
        pop_n <= 1'b0;
        @(posedge clock);
        {pop_n, port_select_n, output_enable_n} <= 3'h7;
        rd(rhp_pkg::IRQ_STATUS_OFFSET, 32'h8, OK);
        // arrivals: two ahead ignored, one ahead taken
        mdl.send_code(8'h02);
        exp_t.push_back(32'h01);
        mdl.send_code(8'h01);
        while (exp_t.size() > 0) @(posedge clock);
        // random time request, then one refused with the link down
        w = 9'($urandom);
        exp_t.push_back(32'(w[7:0]));
        tick_in <= 1'b1;
        time_code_in <= w[7:0];
        @(posedge clock);
        tick_in <= 1'b0;
        time_code_in <= ~w[7:0];
        while (exp_t.size() > 0) @(posedge clock);
        {link_run, tick_in} <= 2'h1;
        @(posedge clock);
        tick_in <= 1'b0;
        rd(rhp_pkg::STATUS_OFFSET, 32'h0C, OK);
        rd(rhp_pkg::TIME_OFFSET, 32'h01, OK);
        finish_test();
    end
endmodule
